// ---- core/tape_cmd_pkg.sv ----
// Operation
// - Code 01000 selects the five positioning modes
// - Code 01001 selects mark, erase, retry-mark formats
// - Control, initialize and get-status codes and modes
// - Code bits 4:3 give the packet length
// - Swap one stores even byte first
// - Swap zero stores odd byte first
// - Swap control matters only for data transfers
// - Record bytes numbered from start-nearest end
// - Reverse read fills buffer from the top
// - All four packet words always fetched
// - Parity error in any packet word rejects it
// - Get-status refreshes five extended status words
// - Every command end refreshes extended status words
// - Exact length read ends normal, no flags
// - Short record sets short flag and alert
// - Long record sets long flag and alert
// - Tape mark: no data, mark, short, alert
// - Reverse into start sets flag, stops, alerts
// - Reverse read at start rejected, no motion
// - Code 00001 selects the four read modes
// - Header holds mode 11:8 and code 4:0
// - Format field 100 enables completion interrupt
package tape_cmd_pkg;
    localparam int WORD_W  = 16;
    localparam int ADDR_W  = 18;
    localparam int PKT_WORDS = 4;
    localparam int EXT_WORDS = 5;
    // Register byte addresses on the plain software port
    localparam logic [7:0] REG_PKT_PTR  = 8'h00;
    localparam logic [7:0] REG_MSG_BASE = 8'h04;
    localparam logic [7:0] REG_STATUS   = 8'h08;
    localparam logic [7:0] REG_HEADER   = 8'h0c;
    localparam logic [7:0] REG_RESIDUE  = 8'h10;
    // Extended status words sit this many bytes into the message buffer
    localparam logic [ADDR_W-1:0] EXT_OFS = 18'h00006;
    // Header fields
    localparam int HDR_SWAP  = 12;
    localparam int MODE_HI   = 11;
    localparam int MODE_LO   = 8;
    localparam int FMT_HI    = 7;
    localparam int FMT_LO    = 5;
    localparam int CODE_HI   = 4;
    localparam int CODE_LO   = 0;
    localparam logic [2:0] FMT_IRQ_ON  = 3'h4;
    localparam logic [2:0] FMT_IRQ_OFF = 3'h0;
    localparam logic [1:0] LEN_FOUR    = 2'h0;
    // Command codes
    localparam logic [4:0] CMD_READ   = 5'h01;
    localparam logic [4:0] CMD_POS    = 5'h08;
    localparam logic [4:0] CMD_FMT    = 5'h09;
    localparam logic [4:0] CMD_CTRL   = 5'h0a;
    localparam logic [4:0] CMD_INIT   = 5'h0b;
    localparam logic [4:0] CMD_STAT   = 5'h0f;
    // Modes
    localparam logic [3:0] RD_FWD      = 4'h0;
    localparam logic [3:0] RD_REV      = 4'h1;
    localparam logic [3:0] RD_REREAD_P = 4'h2;
    localparam logic [3:0] RD_REREAD_N = 4'h3;
    localparam logic [3:0] POS_LAST    = 4'h4;
    localparam logic [3:0] FMT_LAST    = 4'h2;
    localparam logic [3:0] CTRL_LAST   = 4'h2;
    localparam logic [3:0] MODE_ZERO   = 4'h0;

    typedef enum logic [1:0] {
        TERM_NORMAL = 2'b00,
        TERM_ALERT  = 2'b01,
        TERM_REJECT = 2'b10
    } term_t;

    typedef struct packed {
        logic record_short_flag;
        logic record_long_flag;
        logic tape_mark_seen;
        logic reversed_into_start;
        logic function_reject;
        logic tape_status_alert;
    } flags_t;

    typedef struct packed {
        logic [4:0] code;
        logic [3:0] mode;
    } drive_cmd_t;
endpackage

// ---- core/tape_command_packet_decoder.sv ----
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/100ps
module tape_command_packet_decoder
    import tape_cmd_pkg::*;
#(
    parameter int AW = ADDR_W
) (
    input  wire logic                  core_clk_i,
    input  wire logic                  srst_i,
    // Software register port
    input  wire logic [7:0]            reg_addr_i,
    input  wire logic [31:0]           reg_wdata_i,
    input  wire logic                  reg_wr_i,
    input  wire logic                  reg_rd_i,
    output logic      [31:0]           reg_rdata_o,
    // Host memory port, one request held until acknowledged
    output logic                       mem_req_o,
    output logic                       mem_we_o,
    output logic      [AW-1:0]         mem_addr_o,
    output logic      [1:0]            mem_be_o,
    output logic      [WORD_W-1:0]     mem_wdata_o,
    input  wire logic                  mem_ack_i,
    input  wire logic [WORD_W-1:0]     mem_rdata_i,
    input  wire logic                  mem_perr_i,
    // Drive side
    output drive_cmd_t                 drive_cmd_o,
    output logic                       drive_start_o,
    output logic                       drive_stop_o,
    input  wire logic                  drive_done_i,
    input  wire logic [7:0]            tape_byte_i,
    input  wire logic                  tape_byte_valid_i,
    output logic                       tape_byte_ready_o,
    input  wire logic                  tape_rec_end_i,
    input  wire logic                  tape_mark_i,
    input  wire logic                  beginning_of_tape_i,
    // Completion
    output logic                       cmd_done_o,
    output logic                       cmd_irq_o,
    output logic                       busy_o
);

    initial begin
        if (AW < 8 || AW > 31) begin
            $error("tape_command_packet_decoder: AW out of range");
        end
    end

    typedef enum logic [2:0] {
        S_IDLE   = 3'b000,
        S_FETCH  = 3'b001,
        S_DECODE = 3'b010,
        S_START  = 3'b011,
        S_XFER   = 3'b100,
        S_WAIT   = 3'b101,
        S_STATUS = 3'b110,
        S_DONE   = 3'b111
    } state_t;

    state_t                    state;
    state_t                    next_state;
    logic [AW-1:0]             pkt_ptr;
    logic [AW-1:0]             msg_base;
    logic [WORD_W-1:0]         pkt [PKT_WORDS];
    logic [2:0]                fidx;
    logic [2:0]                sidx;
    logic                      perr_seen;
    logic [WORD_W-1:0]         xcnt;
    flags_t                    flags;
    term_t                     term;
    logic                      bot_meta;
    logic                      bot_sync;

    //////////////////////////////////////////////////////////////////////////////
    // Header decode
    logic [4:0]        code;
    logic [3:0]        mode;
    logic [2:0]        fmt;
    logic              swap;
    logic [AW-1:0]     buf_addr;
    logic [WORD_W-1:0] byte_count;
    logic              is_read;
    logic              is_rev;
    logic              legal;
    logic              reject_now;

    assign code = pkt[0][CODE_HI:CODE_LO];
    assign mode = pkt[0][MODE_HI:MODE_LO];
    assign fmt  = pkt[0][FMT_HI:FMT_LO];
    assign swap = pkt[0][HDR_SWAP];
    // Address and count words exist only in the four-word layout
    assign buf_addr   = (code[4:3] == LEN_FOUR) ?
                        AW'({pkt[2], pkt[1]}) : '0;
    assign byte_count = (code[4:3] == LEN_FOUR) ? pkt[3] : '0;
    assign is_read = (code == CMD_READ);
    // Reread-next spaces forward and then reads reverse
    assign is_rev  = is_read && (mode == RD_REV || mode == RD_REREAD_N);

    always_comb begin
        case (code)
            CMD_READ: legal = (mode <= RD_REREAD_N);
            CMD_POS:  legal = (mode <= POS_LAST);
            CMD_FMT:  legal = (mode <= FMT_LAST);
            CMD_CTRL: legal = (mode <= CTRL_LAST);
            CMD_INIT: legal = (mode == MODE_ZERO);
            CMD_STAT: legal = (mode == MODE_ZERO);
            default:  legal = 1'b0;
        endcase
    end

    // Only the plain reverse read starts at the tape's start without spacing first
    assign reject_now = perr_seen || !legal ||
                        (is_read && mode == RD_REV && bot_sync);
    //////////////////////////////////////////////////////////////////////////////
    // Start-of-tape pin synchroniser
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            bot_meta <= 1'b0;
            bot_sync <= 1'b0;
        end else begin
            bot_meta <= beginning_of_tape_i;
            bot_sync <= bot_meta;
        end
    end
    //////////////////////////////////////////////////////////////////////////////
    // Data transfer handshakes
    logic byte_take;
    logic end_take;
    logic mark_take;
    logic bot_hit;
    logic room;

    assign tape_byte_ready_o = (state == S_XFER) && !mem_req_o;
    assign byte_take = tape_byte_ready_o && tape_byte_valid_i &&
                       !tape_mark_i && !bot_hit;
    assign end_take  = tape_byte_ready_o && !tape_byte_valid_i && tape_rec_end_i;
    assign mark_take = tape_byte_ready_o && tape_mark_i;
    assign bot_hit   = tape_byte_ready_o && is_rev && bot_sync;
    assign room      = (xcnt < byte_count);

    // Byte k of the record lands at buffer+k going forward, from the top in reverse
    logic [AW-1:0] byte_pos;
    assign byte_pos = is_rev ?
                      AW'(buf_addr + AW'(byte_count) - AW'(1) - AW'(xcnt)) :
                      AW'(buf_addr + AW'(xcnt));
    //////////////////////////////////////////////////////////////////////////////
    // Control state machine
    always_comb begin
        next_state = state;
        case (state)
            S_IDLE:   if (reg_wr_i && reg_addr_i == REG_PKT_PTR) begin
                          next_state = S_FETCH;
                      end
            S_FETCH:  if (fidx == 3'(PKT_WORDS)) begin
                          next_state = S_DECODE;
                      end
            S_DECODE: if (reject_now || code == CMD_STAT) begin
                          next_state = S_STATUS;
                      end else begin
                          next_state = S_START;
                      end
            S_START:  next_state = is_read ? S_XFER : S_WAIT;
            S_XFER:   if (end_take || mark_take || bot_hit) begin
                          next_state = S_STATUS;
                      end
            S_WAIT:   if (drive_done_i) begin
                          next_state = S_STATUS;
                      end
            S_STATUS: if (sidx == 3'(EXT_WORDS)) begin
                          next_state = S_DONE;
                      end
            S_DONE:   next_state = S_IDLE;
            default:  next_state = S_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            state <= S_IDLE;
        end else begin
            state <= next_state;
        end
    end
    //////////////////////////////////////////////////////////////////////////////
    // Host memory port: fetch, data bytes, status words
    logic [WORD_W-1:0] ext_word;
    always_comb begin
        case (sidx)
            3'h0:    ext_word = WORD_W'({term, flags});
            3'h1:    ext_word = room ? WORD_W'(byte_count - xcnt) : '0;
            3'h2:    ext_word = pkt[0];
            3'h3:    ext_word = xcnt;
            default: ext_word = '0;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            mem_req_o   <= 1'b0;
            mem_we_o    <= 1'b0;
            mem_addr_o  <= '0;
            mem_be_o    <= 2'h0;
            mem_wdata_o <= '0;
            fidx        <= 3'h0;
            sidx        <= 3'h0;
            perr_seen   <= 1'b0;
            xcnt        <= '0;
            for (int i = 0; i < PKT_WORDS; i++) begin
                pkt[i] <= '0;
            end
        end else begin
            if (mem_req_o && mem_ack_i) begin
                mem_req_o <= 1'b0;
            end
            case (state)
                S_IDLE: begin
                    fidx      <= 3'h0;
                    sidx      <= 3'h0;
                    perr_seen <= 1'b0;
                    xcnt      <= '0;
                end
                S_FETCH: begin
                    // Every word is read even when the command needs only the header
                    if (!mem_req_o && fidx < 3'(PKT_WORDS)) begin
                        mem_req_o  <= 1'b1;
                        mem_we_o   <= 1'b0;
                        mem_be_o   <= 2'h3;
                        mem_addr_o <= AW'(pkt_ptr + AW'({fidx, 1'b0}));
                    end
                    if (mem_req_o && mem_ack_i) begin
                        pkt[fidx[1:0]] <= mem_rdata_i;
                        perr_seen      <= perr_seen | mem_perr_i;
                        fidx           <= fidx + 3'h1;
                    end
                end
                S_XFER: begin
                    if (byte_take && room) begin
                        mem_req_o   <= 1'b1;
                        mem_we_o    <= 1'b1;
                        mem_addr_o  <= {byte_pos[AW-1:1], 1'b0};
                        mem_wdata_o <= {tape_byte_i, tape_byte_i};
                        // Swap puts the even address in the upper lane
                        mem_be_o    <= (byte_pos[0] ^ swap) ? 2'h2 : 2'h1;
                    end
                    if (byte_take) begin
                        xcnt <= xcnt + WORD_W'(1);
                    end
                end
                S_STATUS: begin
                    if (!mem_req_o && sidx < 3'(EXT_WORDS)) begin
                        mem_req_o   <= 1'b1;
                        mem_we_o    <= 1'b1;
                        mem_be_o    <= 2'h3;
                        mem_addr_o  <= AW'(msg_base + EXT_OFS + AW'({sidx, 1'b0}));
                        mem_wdata_o <= ext_word;
                    end
                    if (mem_req_o && mem_ack_i) begin
                        sidx <= sidx + 3'h1;
                    end
                end
                default: begin
                end
            endcase
        end
    end
    //////////////////////////////////////////////////////////////////////////////
    // Termination flags
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            flags <= '0;
            term  <= TERM_NORMAL;
        end else if (state == S_FETCH) begin
            flags <= '0;
            term  <= TERM_NORMAL;
        end else if (state == S_DECODE && reject_now) begin
            flags.function_reject <= 1'b1;
            term                  <= TERM_REJECT;
        end else if (state == S_XFER) begin
            if (byte_take && !room) begin
                flags.record_long_flag  <= 1'b1;
                flags.tape_status_alert <= 1'b1;
                term                    <= TERM_ALERT;
            end
            if (mark_take) begin
                flags.tape_mark_seen    <= 1'b1;
                flags.record_short_flag <= 1'b1;
                flags.tape_status_alert <= 1'b1;
                term                    <= TERM_ALERT;
            end else if (bot_hit) begin
                flags.reversed_into_start <= 1'b1;
                flags.tape_status_alert   <= 1'b1;
                term                      <= TERM_ALERT;
            end else if (end_take && room) begin
                flags.record_short_flag <= 1'b1;
                flags.tape_status_alert <= 1'b1;
                term                    <= TERM_ALERT;
            end
        end
    end
    //////////////////////////////////////////////////////////////////////////////
    // Drive command and completion outputs
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            drive_cmd_o   <= '0;
            drive_start_o <= 1'b0;
            drive_stop_o  <= 1'b0;
            cmd_done_o    <= 1'b0;
            cmd_irq_o     <= 1'b0;
        end else begin
            drive_start_o <= (state == S_START);
            drive_stop_o  <= bot_hit;
            if (state == S_START) begin
                drive_cmd_o <= '{code: code, mode: mode};
            end
            cmd_done_o <= (state == S_STATUS) && (next_state == S_DONE);
            cmd_irq_o  <= (state == S_STATUS) && (next_state == S_DONE) &&
                          (fmt == FMT_IRQ_ON);
        end
    end

    assign busy_o = (state != S_IDLE);

    //////////////////////////////////////////////////////////////////////////////
    // Software registers; the pointer write only starts a command while idle
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            pkt_ptr     <= '0;
            msg_base    <= '0;
            reg_rdata_o <= '0;
        end else begin
            if (reg_wr_i && reg_addr_i == REG_PKT_PTR && state == S_IDLE) begin
                pkt_ptr <= AW'(reg_wdata_i);
            end
            if (reg_wr_i && reg_addr_i == REG_MSG_BASE && state == S_IDLE) begin
                msg_base <= AW'(reg_wdata_i);
            end
            if (reg_rd_i) begin
                case (reg_addr_i)
                    REG_PKT_PTR:  reg_rdata_o <= 32'(pkt_ptr);
                    REG_MSG_BASE: reg_rdata_o <= 32'(msg_base);
                    REG_STATUS:   reg_rdata_o <= 32'({busy_o, term, flags});
                    REG_HEADER:   reg_rdata_o <= 32'(pkt[0]);
                    REG_RESIDUE:  reg_rdata_o <= 32'(xcnt);
                    default:      reg_rdata_o <= '0;
                endcase
            end else begin
                reg_rdata_o <= '0;
            end
        end
    end
    //////////////////////////////////////////////////////////////////////////////
    // Checks
    logic [AW-1:0] last_pos;
    logic          last_valid;
    always_ff @(posedge core_clk_i) begin
        if (srst_i || state != S_XFER) begin
            last_pos   <= '0;
            last_valid <= 1'b0;
        end else if (byte_take && room) begin
            last_pos   <= byte_pos;
            last_valid <= 1'b1;
        end
    end

    chk_fetch_four: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (state == S_DECODE) |-> (fidx == 3'h4))
        else $error("decode began before four packet words");
    chk_reject_still: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (state == S_DECODE && reject_now) |=> (state == S_STATUS) ##1 !drive_start_o)
        else $error("rejected packet moved the drive");
    chk_undef_reject: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (state == S_DECODE && !legal) |=> flags.function_reject && term == TERM_REJECT)
        else $error("undefined command not rejected");
    chk_parity_reject: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (state == S_DECODE && perr_seen) |=> flags.function_reject)
        else $error("parity error in packet not rejected");
    chk_irq_gate: assert property (@(posedge core_clk_i) disable iff (srst_i)
        cmd_irq_o |-> cmd_done_o && fmt == FMT_IRQ_ON)
        else $error("completion interrupt without enable");
    chk_status_first: assert property (@(posedge core_clk_i) disable iff (srst_i)
        $rose(cmd_done_o) |-> (sidx == 3'h5) && (state == S_DONE))
        else $error("command ended before status refresh");
    chk_mark_flags: assert property (@(posedge core_clk_i) disable iff (srst_i)
        mark_take |=> flags.tape_mark_seen && flags.record_short_flag
                      && term == TERM_ALERT && state == S_STATUS)
        else $error("tape mark flags wrong");
    chk_long_flag: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (byte_take && !room) |=> flags.record_long_flag && flags.tape_status_alert
                                 && !mem_req_o)
        else $error("overlong record not flagged or stored");
    chk_exact_end: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (end_take && !room && !flags.record_long_flag) |=>
            term == TERM_NORMAL && !flags.tape_status_alert)
        else $error("exact-length read not normal");
    chk_rev_order: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (byte_take && room && is_rev && last_valid) |-> byte_pos == last_pos - AW'(1))
        else $error("reverse read not filling downward");
    chk_bot_stop: assert property (@(posedge core_clk_i) disable iff (srst_i)
        bot_hit |=> drive_stop_o && flags.reversed_into_start)
        else $error("reverse into start not stopped");
endmodule // tape_command_packet_decoder

// ---- dv/host_mem_model.sv ----
`timescale 1ns/100ps
module host_mem_model
    import tape_cmd_pkg::*;
(
    input  wire logic              core_clk_i,
    input  wire logic              mem_req_o,
    input  wire logic              mem_we_o,
    input  wire logic [ADDR_W-1:0] mem_addr_o,
    input  wire logic [1:0]        mem_be_o,
    input  wire logic [WORD_W-1:0] mem_wdata_o,
    input  wire logic [3:0]        slow_i,
    input  wire logic [ADDR_W-1:0] perr_addr_i,
    output logic                   mem_ack_i,
    output logic [WORD_W-1:0]      mem_rdata_i,
    output logic                   mem_perr_i
);
    logic [WORD_W-1:0] mem [256];
    logic [3:0]        wait_cnt = 4'h0;
    initial {mem_ack_i, mem_rdata_i, mem_perr_i} = '0;
    always @(posedge core_clk_i) begin
        mem_ack_i <= 1'b0;
        mem_perr_i <= 1'b0;
        // Idle read bus toggles so a stale word is never mistaken for data
        mem_rdata_i <= ~mem_rdata_i;
        if (mem_req_o && !mem_ack_i) begin
            wait_cnt <= wait_cnt + 4'h1;
            if (wait_cnt >= slow_i) begin
                wait_cnt <= 4'h0;
                mem_ack_i <= 1'b1;
                mem_rdata_i <= mem[mem_addr_o[8:1]];
                mem_perr_i <= mem_addr_o == perr_addr_i;
                if (mem_we_o && mem_be_o[0]) mem[mem_addr_o[8:1]][7:0] <= mem_wdata_o[7:0];
                if (mem_we_o && mem_be_o[1]) mem[mem_addr_o[8:1]][15:8] <= mem_wdata_o[15:8];
            end
        end
    end
endmodule // host_mem_model

// ---- dv/tb.sv ----
`timescale 1ns/100ps
module tb;
    import tape_cmd_pkg::*;
    logic core_clk_i = 1'b0, srst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0, drive_done_i = 1'b0;
    logic tape_byte_valid_i = 1'b0, tape_rec_end_i = 1'b0, tape_mark_i = 1'b0;
    logic beginning_of_tape_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00, tape_byte_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o;
    logic [3:0] slow_i = 4'h0;
    logic [ADDR_W-1:0] perr_addr_i = '1, mem_addr_o;
    logic mem_req_o, mem_we_o, mem_ack_i, mem_perr_i, drive_start_o, drive_stop_o;
    logic cmd_done_o, cmd_irq_o, busy_o, tape_byte_ready_o;
    logic [1:0] mem_be_o, dly = 2'h0;
    logic [15:0] mem_wdata_o, mem_rdata_i;
    drive_cmd_t drive_cmd_o;
    int error_cnt = 0, n_compared = 0, n_rd = 0, n_start = 0;
    logic [4:0] tcode [6] = '{CMD_POS, CMD_FMT, CMD_CTRL, CMD_INIT, CMD_STAT, 5'h0c};
    int tlast [6] = '{4, 2, 2, 0, 0, -1};

    tape_command_packet_decoder uut (.*);
    host_mem_model mdl (.*);

    initial forever #10 core_clk_i = !core_clk_i;
    // Non-read drive operations finish three cycles after their start pulse
    always @(posedge core_clk_i) begin
        dly <= {dly[0], drive_start_o && drive_cmd_o.code != CMD_READ};
        drive_done_i <= dly[1];
        n_rd += mem_ack_i && !mem_we_o;
        n_start += drive_start_o;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic reg_io(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} <= {w, !w, a, d};
        @(posedge core_clk_i);
        {reg_wr_i, reg_rd_i} <= 2'b00;
        @(negedge core_clk_i);
    endtask
    // Packet at 0x40; buffer at 0x80, or 0x90 for odd modes
    task automatic run(input logic [15:0] hdr, input logic [7:0] cnt, input logic [7:0] nb,
                       input logic mk, input logic [8:0] exp_st, input logic [8:0] mask);
        mdl.mem[8'h20] = hdr;
        mdl.mem[8'h21] = {8'h00, 3'b100, hdr[8], 4'h0};
        mdl.mem[8'h22] = 16'h0000;
        mdl.mem[8'h23] = {8'h00, cnt};
        mdl.mem[8'h83] = 16'hdead;
        n_rd = 0;
        n_start = 0;
        reg_io(1'b1, REG_PKT_PTR, 32'h40);
        while (!cmd_done_o) begin
            if (drive_start_o && hdr[4:0] == CMD_READ) begin
                // A run into the start of tape ends the command before all bytes are taken
                for (int k = 0; k <= nb && !cmd_done_o; k++) begin
                    @(posedge core_clk_i);
                    tape_byte_i <= 8'ha0 + k[7:0];
                    tape_byte_valid_i <= k < nb;
                    tape_rec_end_i <= k == nb && !mk;
                    tape_mark_i <= k == nb && mk;
                    do @(negedge core_clk_i); while (!tape_byte_ready_o && !cmd_done_o);
                end
                if (!cmd_done_o) @(posedge core_clk_i);
                {tape_byte_valid_i, tape_rec_end_i, tape_mark_i} <= 3'b000;
            end
            if (!cmd_done_o) @(negedge core_clk_i);
        end
        chk(cmd_irq_o, hdr[7:5] == FMT_IRQ_ON);
        chk(n_rd, 4);
        chk(n_start, !exp_st[7] && hdr[4:0] != CMD_STAT);
        if (n_start > 0) chk(drive_cmd_o, {hdr[4:0], hdr[11:8]});
        if (exp_st == 9'h000) chk(mdl.mem[8'h83], 32'h0);
        reg_io(1'b0, REG_STATUS, 32'h0);
        chk(reg_rdata_o[8:0] & mask, exp_st);
    endtask
    task automatic complete_run;
        $display("compared=%0d errors=%0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #1000000;
        error_cnt++;
        complete_run;
    end
    initial begin
        repeat (2) @(posedge core_clk_i);
        srst_i <= 1'b0;
        reg_io(1'b1, REG_MSG_BASE, 32'h100);
        run(16'h0081, 8'h4, 8'h4, 1'b0, 9'h000, 9'h1ff);
        chk(mdl.mem[8'h40], 32'ha1a0);
        chk(mdl.mem[8'h41], 32'ha3a2);
        run(16'h1101, 8'h4, 8'h4, 1'b0, 9'h000, 9'h1ff);
        chk(mdl.mem[8'h48], 32'ha3a2);
        chk(mdl.mem[8'h49], 32'ha1a0);
        run(16'h0001, 8'h4, 8'h2, 1'b0, 9'h061, 9'h1ff);
        slow_i <= 4'h3;
        run(16'h0001, 8'h2, 8'h3, 1'b0, 9'h051, 9'h1ff);
        run(16'h0001, 8'h4, 8'h0, 1'b1, 9'h069, 9'h1ff);
        beginning_of_tape_i <= 1'b1;
        run(16'h0101, 8'h4, 8'h0, 1'b0, 9'h082, 9'h0c2);
        run(16'h0301, 8'h4, 8'h2, 1'b0, 9'h045, 9'h1ff);
        beginning_of_tape_i <= 1'b0;
        perr_addr_i <= 18'h46;
        run(16'h0008, 8'h0, 8'h0, 1'b0, 9'h082, 9'h0c2);
        perr_addr_i <= '1;
        slow_i <= 4'h0;
        // Every defined non-read mode plus one past the last, swap and irq alternating
        foreach (tcode[i]) for (int m = 0; m <= tlast[i] + 1; m++)
            run({3'h0, m[0], m[3:0], m[0], 2'h0, tcode[i]}, 8'h0, 8'h0, 1'b0,
                (m > tlast[i]) ? 9'h082 : 9'h000, 9'h0c2);
        complete_run;
    end
endmodule // tb
